// *** rtl/output_compare_fault_trigger_ctrl.v ***
// Purpose: Second control register of a compare channel and the output path it governs.
// Assumes: Compare datapath, fault source and period start come in as ports.
// Notes:   Registers sit on an Avalon-MM slave with waitrequest.
//
// Local design decisions: the Avalon-MM register port and the address map.
`timescale 1ns/1ps
`include "oc_fault_trigger_consts.vh"

module output_compare_fault_trigger_ctrl
(
	// Clock and reset
	input  wire        i_mclk,
	input  wire        i_srst,
	// Avalon-MM slave
	input  wire [1:0]  i_avs_address,
	input  wire        i_avs_read,
	input  wire        i_avs_write,
	input  wire [31:0] i_avs_writedata,
	output reg  [31:0] o_avs_readdata,
	output wire        o_avs_waitrequest,
	// Channel events
	input  wire        i_fault,
	input  wire        i_period_start,
	input  wire        i_compare_match,
	input  wire        i_compare_low_match,
	input  wire        i_compare_high_match,
	input  wire [31:0] i_sync_sources,
	input  wire [3:0]  i_pattern_trigger_output,
	// Channel outputs
	output reg         o_pin_out,
	output reg         o_pin_oe,
	output reg         o_fault_active,
	output reg         o_running,
	output reg         o_sync_reset,
	output reg         o_cascade_wide_en,
	output wire        o_irq
);

	reg  [15:0]            control_2;
	reg  [`IRQ_WIDTH-1:0]  irq_status;
	reg  [`IRQ_WIDTH-1:0]  irq_mask;
	reg                    fault_clear_req;
	reg                    ack;
	reg  [15:0]            next_control_2;
	reg                    src;
	wire [4:0]             sync_source_sel;
	wire                   wr;
	wire                   rd;
	wire                   source_hit;
	wire                   fault_exit;
	wire                   match_path;
	wire                   drive_level;

	// ------------------------------------------------------------
	// Bus slave: one wait state, answer on the second cycle.
	// ------------------------------------------------------------
	assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack;
	assign wr = i_avs_write & ack;
	assign rd = i_avs_read & ~ack;

	always @(posedge i_mclk)
	begin
		if (i_srst)
			ack <= 1'b0;
		else
			ack <= (i_avs_read | i_avs_write) & ~ack;
	end

	always @(posedge i_mclk)
	begin
		if (i_srst)
			o_avs_readdata <= 32'h00000000;
		else if (rd)
		begin
			case (i_avs_address)
				`ADDR_CONTROL_2:  o_avs_readdata <= {16'h0000, control_2};
				`ADDR_IRQ_STATUS: o_avs_readdata <= {29'h00000000, irq_status};
				`ADDR_IRQ_MASK:   o_avs_readdata <= {29'h00000000, irq_mask};
				`ADDR_CH_STATUS:  o_avs_readdata <= {29'h00000000, o_running,
					o_fault_active, fault_clear_req};
				default:          o_avs_readdata <= 32'h00000000;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Source selection.
	// ------------------------------------------------------------
	assign sync_source_sel = control_2[`SEL_HI:`SEL_LO];

	always @*
	begin
		src = i_sync_sources[sync_source_sel];
		if (sync_source_sel == `SEL_PATTERN_BASE)
			src = i_pattern_trigger_output[`CHANNEL_INDEX];
	end

	assign source_hit = src;

	// ------------------------------------------------------------
	// Control register with hardware-set trigger flag.
	// ------------------------------------------------------------
	always @*
	begin
		next_control_2 = control_2;
		if (wr && i_avs_address == `ADDR_CONTROL_2)
			next_control_2 = i_avs_writedata[15:0] & `CONTROL_2_WMASK;
		if (control_2[`BIT_TRIG_MODE] && source_hit)
			next_control_2[`BIT_TRIG_SEEN] = 1'b1;
	end

	always @(posedge i_mclk)
	begin
		if (i_srst)
			control_2 <= `CONTROL_2_RESET;
		else
			control_2 <= next_control_2;
	end

	// ------------------------------------------------------------
	// Trigger and synchronization operation.
	// ------------------------------------------------------------
	always @(posedge i_mclk)
	begin
		if (i_srst)
		begin
			o_running    <= 1'b0;
			o_sync_reset <= 1'b0;
		end
		else if (control_2[`BIT_TRIG_MODE])
		begin
			o_sync_reset <= 1'b0;
			o_running    <= next_control_2[`BIT_TRIG_SEEN];
		end
		else
		begin
			o_running    <= 1'b1;
			o_sync_reset <= source_hit;
		end
	end

	// ------------------------------------------------------------
	// Fault handling.
	// ------------------------------------------------------------
	assign fault_exit = o_fault_active & i_period_start & ~i_fault &
		(~control_2[`BIT_FAULT_HOLD] | fault_clear_req);

	always @(posedge i_mclk)
	begin
		if (i_srst)
		begin
			o_fault_active  <= 1'b0;
			fault_clear_req <= 1'b0;
		end
		else
		begin
			if (i_fault)
				o_fault_active <= 1'b1;
			else if (fault_exit)
				o_fault_active <= 1'b0;
			if (i_fault || fault_exit)
				fault_clear_req <= 1'b0;
			else if (wr && i_avs_address == `ADDR_CH_STATUS && i_avs_writedata[0])
				fault_clear_req <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// Output path.
	// ------------------------------------------------------------
	assign match_path  = control_2[`BIT_CASCADE] ?
		(i_compare_low_match & i_compare_high_match) : i_compare_match;
	assign drive_level = match_path ^ control_2[`BIT_INVERT];

	always @(posedge i_mclk)
	begin
		if (i_srst)
		begin
			o_pin_out         <= 1'b0;
			o_pin_oe          <= 1'b0;
			o_cascade_wide_en <= 1'b0;
		end
		else
		begin
			o_cascade_wide_en <= control_2[`BIT_CASCADE];
			if (o_fault_active)
			begin
				o_pin_out <= control_2[`BIT_FAULT_LEVEL];
				o_pin_oe  <= ~control_2[`BIT_FAULT_TRI] & ~control_2[`BIT_PIN_TRI];
			end
			else
			begin
				o_pin_out <= o_running & drive_level;
				o_pin_oe  <= ~control_2[`BIT_PIN_TRI];
			end
		end
	end

	// ------------------------------------------------------------
	// Interrupts: sticky, write one to clear, set wins.
	// ------------------------------------------------------------
	always @(posedge i_mclk)
	begin
		if (i_srst)
		begin
			irq_status <= 3'h0;
			irq_mask   <= 3'h0;
		end
		else
		begin
			if (wr && i_avs_address == `ADDR_IRQ_MASK)
				irq_mask <= i_avs_writedata[`IRQ_WIDTH-1:0];
			irq_status <= ((wr && i_avs_address == `ADDR_IRQ_STATUS) ?
				(irq_status & ~i_avs_writedata[`IRQ_WIDTH-1:0]) : irq_status) |
				{fault_exit, i_fault & ~o_fault_active,
				control_2[`BIT_TRIG_MODE] & source_hit & ~control_2[`BIT_TRIG_SEEN]};
		end
	end

	assign o_irq = |(irq_status & irq_mask);

endmodule // output_compare_fault_trigger_ctrl

// *** rtl/oc_fault_trigger_consts.vh ***
// Purpose: Constants for the output compare fault and trigger control block.
// Assumes: Avalon-MM word addressing, 32-bit data, 16-bit register in low bits.
// Notes:   Offsets are word indices.
`ifndef OC_FAULT_TRIGGER_CONSTS_VH
`define OC_FAULT_TRIGGER_CONSTS_VH

`define ADDR_CONTROL_2      2'h0
`define ADDR_IRQ_STATUS     2'h1
`define ADDR_IRQ_MASK       2'h2
`define ADDR_CH_STATUS      2'h3

`define BIT_FAULT_HOLD      15
`define BIT_FAULT_LEVEL     14
`define BIT_FAULT_TRI       13
`define BIT_INVERT          12
`define BIT_CASCADE         8
`define BIT_TRIG_MODE       7
`define BIT_TRIG_SEEN       6
`define BIT_PIN_TRI         5
`define SEL_HI              4
`define SEL_LO              0

`define CONTROL_2_RESET     16'h000C
`define CONTROL_2_WMASK     16'hF1FF

`define IRQ_TRIGGER         0
`define IRQ_FAULT_ENTER     1
`define IRQ_FAULT_EXIT      2
`define IRQ_WIDTH           3

`define SEL_PATTERN_BASE    5'h01
`define CHANNEL_INDEX       2'h0

`endif

// *** verif/oc_ctrl_monitor.sv ***
// Purpose: Port checks for the compare channel control block.
// Assumes: Control word shadowed from bus writes at word 0.
// Notes:   Bound into every instance.
`timescale 1ns/1ps
`include "oc_fault_trigger_consts.vh"
module oc_ctrl_monitor
(
	input wire        i_mclk,
	input wire        i_srst,
	input wire [1:0]  i_avs_address,
	input wire        i_avs_write,
	input wire [31:0] i_avs_writedata,
	input wire        o_avs_waitrequest,
	input wire        i_compare_match,
	input wire        i_period_start,
	input wire [3:0]  i_pattern_trigger_output,
	input wire        o_pin_out,
	input wire        o_pin_oe,
	input wire        o_fault_active,
	input wire        o_running,
	input wire        o_sync_reset,
	input wire        o_cascade_wide_en
);
	logic [15:0] ctl;
	always_ff @(posedge i_mclk)
		if (i_srst)
			ctl <= `CONTROL_2_RESET;
		else if (i_avs_write && !o_avs_waitrequest && i_avs_address == 2'h0)
			ctl <= i_avs_writedata[15:0] & `CONTROL_2_WMASK;
	default clocking @(posedge i_mclk); endclocking
	default disable iff (i_srst);
	sequence settled; $stable(ctl) [*2]; endsequence
	sequence steady_fault; ($stable(ctl) && o_fault_active) [*2]; endsequence
	cascade_follow_a: assert property (settled |-> o_cascade_wide_en == ctl[8])
		else $error("cascade flag differs from control");
	pin_release_a: assert property (settled ##0 ctl[5] |-> !o_pin_oe)
		else $error("pin driven while released");
	fault_level_a: assert property (steady_fault ##0 !ctl[13] && !ctl[5]
		|-> o_pin_oe && o_pin_out == ctl[14]) else $error("fault level not driven");
	fault_tri_a: assert property (steady_fault ##0 ctl[13] |-> !o_pin_oe)
		else $error("pin driven in fault with tri-state set");
	fault_hold_a: assert property (o_fault_active && !i_period_start |=> o_fault_active)
		else $error("fault left without a new period");
	invert_path_a: assert property (!o_fault_active && !$past(o_fault_active)
		&& !$past(ctl[8]) && !$past(ctl[5])
		|-> o_pin_out == $past(o_running && (i_compare_match ^ ctl[12])))
		else $error("compare output polarity wrong");
	trigger_start_a: assert property (ctl[7] && ctl[4:0] == `SEL_PATTERN_BASE
		&& i_pattern_trigger_output[0] |-> ##[1:2] o_running) else $error("no trigger start");
	sync_follow_a: assert property (settled ##0 !ctl[7] && ctl[4:0] == `SEL_PATTERN_BASE
		|=> o_sync_reset == $past(i_pattern_trigger_output[0])) else $error("sync not followed");
endmodule // oc_ctrl_monitor
bind output_compare_fault_trigger_ctrl oc_ctrl_monitor i_oc_ctrl_monitor (.*);

// *** verif/tb_top.sv ***
// Purpose: Self-checking bench for the compare channel control block.
// Assumes: Channel index 0, so select code 1 picks pattern trigger bit 0.
// Notes:   Checks are taken at the falling edge, after outputs settle.
`timescale 1ns/1ps
`include "oc_fault_trigger_consts.vh"
module tb_top;
	logic        i_mclk = 0, i_srst = 1, i_avs_read = 0, i_avs_write = 0;
	logic [1:0]  i_avs_address = 0;
	logic [31:0] i_avs_writedata = 0, i_sync_sources = 0, rd, d, o_avs_readdata;
	logic        i_fault = 0, i_period_start = 0, i_compare_match = 0, m1 = 0, m2 = 0, q;
	logic        i_compare_low_match = 0, i_compare_high_match = 0;
	logic [3:0]  i_pattern_trigger_output = 0;
	logic        o_avs_waitrequest, o_pin_out, o_pin_oe, o_fault_active, o_running;
	logic        o_sync_reset, o_cascade_wide_en, o_irq;
	int          fails = 0, tests_run = 0;
	output_compare_fault_trigger_ctrl i_output_compare_fault_trigger_ctrl (.*);
	always #12.5 i_mclk = ~i_mclk;
	always @(posedge i_mclk)
	begin
		m1 <= i_compare_match;
		m2 <= i_compare_low_match & i_compare_high_match;
		{i_compare_match, i_compare_low_match, i_compare_high_match} <= 3'($urandom);
		i_sync_sources <= $urandom;
	end
	task automatic chk(input [31:0] g, input [31:0] e);
		tests_run++;
		if (g !== e)
		begin
			fails++;
			$display("mismatch at %0t: got %h want %h", $time, g, e);
		end
	endtask
	task automatic bus(input [1:0] a, input w, input [31:0] v);
		@(posedge i_mclk);
		i_avs_address <= a;
		i_avs_write <= w;
		i_avs_read <= !w;
		i_avs_writedata <= v;
		@(posedge i_mclk);
		while (o_avs_waitrequest !== 1'b0)
			@(posedge i_mclk);
		rd = o_avs_readdata;
		i_avs_write <= 0;
		i_avs_read <= 0;
		@(negedge i_mclk);
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge i_mclk);
		@(negedge i_mclk);
	endtask
	task automatic complete_run;
		if (fails == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial
	begin
		repeat (4000) @(posedge i_mclk);
		fails++;
		complete_run();
	end
	initial
	begin
		q = 1'($urandom(32'h1D6E00A8));
		repeat (3) @(posedge i_mclk);
		i_srst <= 0;
		@(posedge i_mclk);
		bus(0, 0, 0);
		chk(rd, 32'h0000000C);
		repeat (4)
		begin
			d = $urandom & 32'h0000F11F;
			bus(0, 1, d);
			bus(0, 0, 0);
			chk(rd, d);
			chk(o_cascade_wide_en, d[8]);
			chk(o_pin_out, (d[8] ? m2 : m1) ^ d[12]);
		end
		bus(0, 1, 32'hFFFFFE3F);
		bus(0, 0, 0);
		chk(rd, 32'h0000F03F);
		chk(o_pin_oe, 0);
		for (int v = 0; v < 2; v++)
		begin
			bus(0, 1, {v[0], 12'h001});
			wt(0);
			chk(o_pin_out, m1 ^ v[0]);
			chk(o_pin_oe, 1);
			@(posedge i_mclk);
		end
		for (int h = 1; h >= 0; h--)
		begin
			bus(0, 1, {h[0], 15'h4001});
			@(posedge i_mclk);
			i_fault <= 1;
			wt(3);
			chk(o_fault_active, 1);
			chk({o_pin_oe, o_pin_out}, 3);
			@(posedge i_mclk);
			bus(0, 1, {h[0], 15'h6001});
			wt(2);
			chk(o_pin_oe, 0);
			@(posedge i_mclk);
			i_fault <= 0;
			@(posedge i_mclk);
			i_period_start <= 1;
			@(posedge i_mclk);
			i_period_start <= 0;
			wt(1);
			chk(o_fault_active, h[0]);
			@(posedge i_mclk);
			bus(`ADDR_CH_STATUS, 1, 1);
			@(posedge i_mclk);
			i_period_start <= 1;
			@(posedge i_mclk);
			i_period_start <= 0;
			wt(1);
			chk(o_fault_active, 0);
			@(posedge i_mclk);
		end
		for (int s = 0; s < 2; s++)
		begin
			i_pattern_trigger_output <= s ? 4'h1 : 4'hE;
			wt(1);
			chk(o_sync_reset, s);
			@(posedge i_mclk);
		end
		i_pattern_trigger_output <= 4'h0;
		bus(`ADDR_IRQ_STATUS, 1, 7);
		bus(0, 1, 32'h81);
		wt(0);
		chk(o_running, 0);
		@(posedge i_mclk);
		i_pattern_trigger_output <= 4'h1;
		@(posedge i_mclk);
		i_pattern_trigger_output <= 4'h0;
		wt(2);
		chk(o_running, 1);
		@(posedge i_mclk);
		bus(0, 0, 0);
		chk(rd[6], 1);
		bus(`ADDR_IRQ_STATUS, 0, 0);
		chk(rd, 32'h00000001);
		bus(`ADDR_IRQ_MASK, 1, 6);
		chk(o_irq, 0);
		bus(`ADDR_IRQ_MASK, 1, 7);
		chk(o_irq, 1);
		bus(0, 1, 32'h81);
		bus(`ADDR_IRQ_STATUS, 1, 7);
		bus(0, 0, 0);
		chk(rd[6], 0);
		chk(o_irq, 0);
		chk(o_running, 0);
		complete_run();
	end
endmodule // tb_top
